// *** logic/lbc_pkg.sv ***
`default_nettype none
package lbc_pkg;
    localparam int unsigned ADDR_W      = 24;
    localparam int unsigned DATA_W      = 16;
    localparam int unsigned IO_HI_LSB   = 16;
    localparam int unsigned CLK_DIV     = 2;
    // Clocks ready stays low after the first; far side filters its pins
    localparam logic [1:0] READY_HOLD   = 2'h3;
    // Byte-lane codes as {upper_byte_lane_enable_n, a0}
    localparam logic [1:0] LANE_WORD    = 2'h0;
    localparam logic [1:0] LANE_UPPER   = 2'h1;
    localparam logic [1:0] LANE_LOWER   = 2'h2;
    localparam logic [1:0] LANE_RSVD    = 2'h3;
    // Status codes as {cycle_status_hi_n, cycle_status_lo_n}
    localparam logic [1:0] ST_00        = 2'h0;
    localparam logic [1:0] ST_01        = 2'h1;
    localparam logic [1:0] ST_10        = 2'h2;
    localparam logic [1:0] ST_IDLE      = 2'h3;
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'hFFFFFF;

    typedef enum logic [2:0] {
        CYC_NONE    = 3'h0,
        CYC_INTACK  = 3'h1,
        CYC_HALT    = 3'h2,
        CYC_MEM_RD  = 3'h3,
        CYC_MEM_WR  = 3'h4,
        CYC_IO_RD   = 3'h5,
        CYC_IO_WR   = 3'h6,
        CYC_FETCH   = 3'h7
    } lbc_cyc_t;

    typedef enum logic [1:0] {
        BS_IDLE   = 2'h0,
        BS_STATUS = 2'h1,
        BS_CMD    = 2'h3,
        BS_HELD   = 2'h2
    } lbc_bus_state_t;

    // Shared cycle decoder; reserved and idle codes give CYC_NONE
    function automatic lbc_cyc_t lbc_decode(input logic cod,
                                            input logic mio,
                                            input logic [1:0] st,
                                            input logic a1);
        lbc_cyc_t r;
        r = CYC_NONE;
        case ({cod, mio})
            2'h0: r = (st == ST_00) ? CYC_INTACK : CYC_NONE;
            2'h1: begin
                if (st == ST_00) begin
                    r = CYC_HALT;
                end else if (st == ST_01) begin
                    r = CYC_MEM_RD;
                end else if (st == ST_10) begin
                    r = CYC_MEM_WR;
                end
            end
            2'h2: begin
                if (st == ST_01) begin
                    r = CYC_IO_RD;
                end else if (st == ST_10) begin
                    r = CYC_IO_WR;
                end
            end
            default: r = (st == ST_01) ? CYC_FETCH : CYC_NONE;
        endcase
        return r;
    endfunction
endpackage
`default_nettype wire

// *** logic/lbc_bus_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface lbc_bus_if;
    logic [23:0] addr;
    logic [23:0] addr_oe;
    logic        upper_byte_lane_enable_n;
    logic        ube_oe;
    logic        cycle_status_hi_n;
    logic        cycle_status_lo_n;
    logic        status_oe;
    logic        mem_io_select;
    logic        fetch_or_intack_select;
    logic        sel_oe;
    logic [15:0] data_cpu;
    logic [15:0] data_cpu_oe;
    logic [15:0] data_ext;
    logic [15:0] data_ext_oe;
    logic        ready_n;
    logic        bus_req;
    logic        bus_grant_out;
    logic        phase_reset;

    modport cpu (
        output addr, addr_oe, upper_byte_lane_enable_n, ube_oe,
        output cycle_status_hi_n, cycle_status_lo_n, status_oe,
        output mem_io_select, fetch_or_intack_select, sel_oe,
        output data_cpu, data_cpu_oe, bus_grant_out,
        input  data_ext, data_ext_oe, ready_n, bus_req, phase_reset
    );
    modport ctl (
        input  addr, addr_oe, upper_byte_lane_enable_n, ube_oe,
        input  cycle_status_hi_n, cycle_status_lo_n, status_oe,
        input  mem_io_select, fetch_or_intack_select, sel_oe,
        input  data_cpu, data_cpu_oe, bus_grant_out,
        output data_ext, data_ext_oe, ready_n, bus_req, phase_reset
    );
endinterface
`default_nettype wire

// *** logic/lbc_cpu_end.sv ***
// Operation
// RULE1: Processor cycle is two system clocks.
// RULE2: Reset rising edge aligns divider phase.
// RULE3: Sample data on reads, drive on writes.
// RULE4: Release data while granted, keep last level.
// RULE5: I/O cycles drive address 23..16 low.
// RULE6: Address bit 0 low for lower lane.
// RULE7: Address outputs float while bus granted.
// RULE8: Upper lane enable low for upper byte.
// RULE9: Lane codes word, upper, lower, reserved.
// RULE10: Status lines low mark cycle start.
// RULE11: Status lines float high while granted.
// RULE12: Intack decode, code low, memory low.
// RULE13: Halt, shutdown, memory read and write decode; shutdown decodes as CYC_HALT.
// RULE14: Both status high means no cycle.
// RULE15: I/O read, write and fetch decode.
// RULE16: Memory select high for memory and halt.
// RULE17: Wait for ready low; ignore while held.
// RULE18: Float on request, then grant; reclaim.
// RULE19: Never emit reserved lane or status codes.
`timescale 1ns/100ps
`default_nettype none
module lbc_cpu_end (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    lbc_bus_if.cpu           bus,
    input  wire logic        req_valid,
    input  wire lbc_pkg::lbc_cyc_t req_cyc,
    input  wire logic [23:0] req_addr,
    input  wire logic [1:0]  req_lanes,
    input  wire logic [15:0] req_wdata,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic [15:0]      rsp_rdata,
    output logic             proc_phase
);
    logic [2:0]  rst_sync_q;
    logic [2:0]  req_sync_q;
    logic [2:0]  rdy_sync_q;
    logic        rst_lvl_q;
    logic        req_lvl_q;
    logic        rdy_lvl_q;
    logic        phase_q;
    lbc_pkg::lbc_bus_state_t st_q;
    lbc_pkg::lbc_cyc_t cyc_q;
    logic        floated_q;
    logic        lane_ok;
    logic        cyc_ok;
    logic        is_rd;
    logic        is_wr;

    // Pins from the far side pass three flops; second and third must agree
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 3'h0;
            req_sync_q <= 3'h0;
            rdy_sync_q <= 3'h7;
        end else begin
            rst_sync_q <= {rst_sync_q[1:0], bus.phase_reset};
            req_sync_q <= {req_sync_q[1:0], bus.bus_req};
            rdy_sync_q <= {rdy_sync_q[1:0], bus.ready_n};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rst_lvl_q <= 1'b0;
            req_lvl_q <= 1'b0;
            rdy_lvl_q <= 1'b1;
        end else begin
            if (rst_sync_q[1] == rst_sync_q[2]) rst_lvl_q <= rst_sync_q[2];
            if (req_sync_q[1] == req_sync_q[2]) req_lvl_q <= req_sync_q[2];
            if (rdy_sync_q[1] == rdy_sync_q[2]) rdy_lvl_q <= rdy_sync_q[2];
        end
    end

    // Divide by two; a rising phase_reset forces phase 0
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            phase_q <= 1'b0;
        end else if (rst_sync_q[2] && rst_sync_q[1] && !rst_lvl_q) begin
            phase_q <= 1'b0; // [RULE2]
        end else begin
            phase_q <= ~phase_q; // [RULE1]
        end
    end

    assign proc_phase = phase_q;

    assign lane_ok = (req_lanes != lbc_pkg::LANE_RSVD); // [RULE9]
    assign cyc_ok  = (req_cyc != lbc_pkg::CYC_NONE); // [RULE19]
    assign is_rd   = (cyc_q == lbc_pkg::CYC_MEM_RD) ||
                     (cyc_q == lbc_pkg::CYC_IO_RD) ||
                     (cyc_q == lbc_pkg::CYC_FETCH) ||
                     (cyc_q == lbc_pkg::CYC_INTACK);
    assign is_wr   = (cyc_q == lbc_pkg::CYC_MEM_WR) ||
                     (cyc_q == lbc_pkg::CYC_IO_WR);

    // Bus sequencer; steps only on processor phase 1
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st_q      <= lbc_pkg::BS_IDLE;
            cyc_q     <= lbc_pkg::CYC_NONE;
            floated_q <= 1'b0;
        end else if (phase_q) begin
            case (st_q)
                lbc_pkg::BS_IDLE: begin
                    if (req_lvl_q) begin
                        st_q      <= lbc_pkg::BS_HELD; // [RULE18]
                        floated_q <= 1'b0;
                    end else if (req_valid && lane_ok && cyc_ok) begin
                        st_q  <= lbc_pkg::BS_STATUS; // [RULE10]
                        cyc_q <= req_cyc;
                    end
                end
                lbc_pkg::BS_STATUS: begin
                    st_q <= lbc_pkg::BS_CMD;
                end
                lbc_pkg::BS_CMD: begin
                    if (!rdy_lvl_q) begin
                        st_q <= lbc_pkg::BS_IDLE; // [RULE17]
                    end
                end
                lbc_pkg::BS_HELD: begin
                    // Drivers float two steps before the grant rises
                    floated_q <= 1'b1; // [RULE18]
                    if (!req_lvl_q) begin
                        st_q <= lbc_pkg::BS_IDLE; // [RULE18]
                    end
                end
                default: st_q <= lbc_pkg::BS_IDLE;
            endcase
        end
    end

    // Request handshake and read capture
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            req_ready <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
        end else begin
            req_ready <= phase_q && st_q == lbc_pkg::BS_IDLE && !req_lvl_q
                         && req_valid && lane_ok && cyc_ok;
            rsp_valid <= phase_q && st_q == lbc_pkg::BS_CMD && !rdy_lvl_q;
            if (phase_q && st_q == lbc_pkg::BS_CMD && !rdy_lvl_q && is_rd)
                rsp_rdata <= bus.data_ext; // [RULE3]
        end
    end

    // Pin outputs
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bus.addr                     <= lbc_pkg::ADDR_RST;
            bus.addr_oe                  <= 24'hFFFFFF;
            bus.upper_byte_lane_enable_n <= 1'b1;
            bus.ube_oe                   <= 1'b1;
            bus.cycle_status_hi_n        <= 1'b1;
            bus.cycle_status_lo_n        <= 1'b1;
            bus.status_oe                <= 1'b1;
            bus.mem_io_select            <= 1'b0;
            bus.fetch_or_intack_select   <= 1'b0;
            bus.sel_oe                   <= 1'b1;
            bus.data_cpu                 <= 16'h0000;
            bus.data_cpu_oe              <= 16'h0000;
            bus.bus_grant_out            <= 1'b0;
        end else if (phase_q) begin
            bus.bus_grant_out <= (st_q == lbc_pkg::BS_HELD) && floated_q
                                 && req_lvl_q; // [RULE18]
            if (st_q == lbc_pkg::BS_HELD || (st_q == lbc_pkg::BS_IDLE
                                             && req_lvl_q)) begin
                bus.addr_oe     <= 24'h000000; // [RULE7]
                bus.ube_oe      <= 1'b0; // [RULE8]
                bus.status_oe   <= 1'b0; // [RULE11]
                bus.sel_oe      <= 1'b0;
                bus.data_cpu_oe <= 16'h0000; // [RULE4]
                bus.cycle_status_hi_n <= 1'b1;
                bus.cycle_status_lo_n <= 1'b1;
                if (!req_lvl_q) begin
                    bus.addr_oe   <= 24'hFFFFFF;
                    bus.ube_oe    <= 1'b1;
                    bus.status_oe <= 1'b1;
                    bus.sel_oe    <= 1'b1;
                end
            end else if (st_q == lbc_pkg::BS_IDLE && req_valid && lane_ok
                         && cyc_ok) begin
                bus.addr <= req_addr;
                if (req_cyc == lbc_pkg::CYC_IO_RD ||
                    req_cyc == lbc_pkg::CYC_IO_WR) begin
                    bus.addr[23:lbc_pkg::IO_HI_LSB] <= 8'h00; // [RULE5]
                end
                bus.addr[0] <= req_lanes[0]; // [RULE6]
                bus.upper_byte_lane_enable_n <= req_lanes[1]; // [RULE8]
                bus.mem_io_select <= (req_cyc == lbc_pkg::CYC_HALT) ||
                    (req_cyc == lbc_pkg::CYC_MEM_RD) ||
                    (req_cyc == lbc_pkg::CYC_MEM_WR) ||
                    (req_cyc == lbc_pkg::CYC_FETCH); // [RULE16]
                bus.fetch_or_intack_select <=
                    (req_cyc == lbc_pkg::CYC_IO_RD) ||
                    (req_cyc == lbc_pkg::CYC_IO_WR) ||
                    (req_cyc == lbc_pkg::CYC_FETCH); // [RULE12] [RULE15]
                case (req_cyc)
                    lbc_pkg::CYC_INTACK, lbc_pkg::CYC_HALT: begin
                        bus.cycle_status_hi_n <= 1'b0; // [RULE13]
                        bus.cycle_status_lo_n <= 1'b0;
                    end
                    lbc_pkg::CYC_MEM_WR, lbc_pkg::CYC_IO_WR: begin
                        bus.cycle_status_hi_n <= 1'b1;
                        bus.cycle_status_lo_n <= 1'b0;
                    end
                    default: begin
                        bus.cycle_status_hi_n <= 1'b0;
                        bus.cycle_status_lo_n <= 1'b1;
                    end
                endcase
                bus.data_cpu <= req_wdata;
            end else if (st_q == lbc_pkg::BS_STATUS) begin
                // Status lasts one processor cycle, then returns to 11
                bus.cycle_status_hi_n <= 1'b1; // [RULE14]
                bus.cycle_status_lo_n <= 1'b1;
                bus.data_cpu_oe <= is_wr ? 16'hFFFF : 16'h0000; // [RULE3]
            end else if (st_q == lbc_pkg::BS_CMD && !rdy_lvl_q) begin
                bus.data_cpu_oe <= 16'h0000;
            end
        end
    end
endmodule
`default_nettype wire

// *** logic/lbc_ctl_end.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbc_ctl_end (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    lbc_bus_if.ctl           bus,
    input  wire logic        want_bus,
    input  wire logic        sync_pulse,
    input  wire logic [15:0] rd_data,
    output logic             cyc_valid,
    output lbc_pkg::lbc_cyc_t cyc_type,
    output logic [23:0]      cyc_addr,
    output logic [1:0]       cyc_lanes,
    output logic             wr_valid,
    output logic [15:0]      wr_data,
    output logic             granted
);
    lbc_pkg::lbc_cyc_t dec;
    logic              active_q;
    logic              rd_q;
    logic [1:0]        open_cnt_q;
    logic              wr_seen_q;

    assign dec = lbc_pkg::lbc_decode(bus.fetch_or_intack_select,
                                     bus.mem_io_select,
                                     {bus.cycle_status_hi_n,
                                      bus.cycle_status_lo_n},
                                     bus.addr[1]); // [RULE12] [RULE13] [RULE15]

    // Decode only on status cycles, never while the bus is ours
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cyc_valid <= 1'b0;
            cyc_type  <= lbc_pkg::CYC_NONE;
            cyc_addr  <= 24'h000000;
            cyc_lanes <= lbc_pkg::LANE_RSVD;
            active_q  <= 1'b0;
            rd_q      <= 1'b0;
            open_cnt_q <= 2'h0;
            wr_seen_q <= 1'b0;
            wr_valid  <= 1'b0;
            wr_data   <= 16'h0000;
        end else begin
            cyc_valid <= 1'b0;
            wr_valid  <= 1'b0;
            if (!active_q && bus.status_oe && dec != lbc_pkg::CYC_NONE) begin
                cyc_valid <= 1'b1; // [RULE14]
                cyc_type  <= dec;
                cyc_addr  <= bus.addr;
                cyc_lanes <= {bus.upper_byte_lane_enable_n,
                              bus.addr[0]}; // [RULE9]
                active_q  <= 1'b1;
                open_cnt_q <= lbc_pkg::READY_HOLD;
                wr_seen_q <= 1'b0;
                rd_q      <= (dec != lbc_pkg::CYC_MEM_WR) &&
                             (dec != lbc_pkg::CYC_IO_WR);
            end else if (active_q) begin
                // A one-clock ready would never pass the far side's filter
                if (!rd_q && !wr_seen_q && bus.data_cpu_oe != 16'h0000) begin
                    wr_valid  <= 1'b1; // [RULE3]
                    wr_data   <= bus.data_cpu;
                    wr_seen_q <= 1'b1;
                end
                if (open_cnt_q == 2'h0) begin
                    active_q <= 1'b0; // [RULE17]
                end else begin
                    open_cnt_q <= open_cnt_q - 2'h1;
                end
            end
        end
    end

    // Ready held low; a read is answered by returning data
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            bus.ready_n     <= 1'b1;
            bus.data_ext    <= 16'h0000;
            bus.data_ext_oe <= 16'h0000;
            bus.bus_req     <= 1'b0;
            bus.phase_reset <= 1'b0;
            granted         <= 1'b0;
        end else begin
            bus.ready_n     <= !active_q; // [RULE17]
            bus.data_ext    <= rd_data;
            bus.data_ext_oe <= (active_q && rd_q) ? 16'hFFFF : 16'h0000;
            bus.bus_req     <= want_bus; // [RULE18]
            bus.phase_reset <= sync_pulse; // [RULE2]
            granted         <= bus.bus_grant_out;
        end
    end
endmodule
`default_nettype wire

// *** testbench/lbc_bus_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module lbc_bus_properties (
    input wire logic        core_clk,
    input wire logic        nrst,
    input wire logic [23:0] addr,
    input wire logic [23:0] addr_oe,
    input wire logic        upper_byte_lane_enable_n,
    input wire logic        ube_oe,
    input wire logic        cycle_status_hi_n,
    input wire logic        cycle_status_lo_n,
    input wire logic        status_oe,
    input wire logic        mem_io_select,
    input wire logic        fetch_or_intack_select,
    input wire logic [15:0] data_cpu_oe,
    input wire logic        bus_req,
    input wire logic        bus_grant_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic [1:0] st;
    logic       st_on;
    logic [1:0] last_st_q;
    assign st    = {cycle_status_hi_n, cycle_status_lo_n};
    assign st_on = status_oe && (st != lbc_pkg::ST_IDLE);

    // Kind of the open cycle, so data drive can be judged later
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            last_st_q <= lbc_pkg::ST_IDLE;
        end else if (st_on) begin
            last_st_q <= st;
        end
    end

    sequence st_start;
        !st_on ##1 st_on;
    endsequence
    sequence st_hold;
        st_on ##1 !st_on;
    endsequence

    status_len_a: assert property (st_start |=> st_hold)
        else $error("status state not one processor cycle");
    lane_legal_a: assert property (st_on |-> ube_oe &&
        ({upper_byte_lane_enable_n, addr[0]} != lbc_pkg::LANE_RSVD))
        else $error("reserved byte lane code");
    status_legal_a: assert property (st_on |->
        (fetch_or_intack_select ? (mem_io_select ? st == lbc_pkg::ST_01
                                                 : st != lbc_pkg::ST_00)
                                : (mem_io_select || st == lbc_pkg::ST_00)))
        else $error("reserved cycle status code");
    io_high_zero_a: assert property (st_on && fetch_or_intack_select &&
        !mem_io_select |-> addr[23:16] == 8'h00 && addr_oe == 24'hFFFFFF)
        else $error("io address high byte not low");
    float_held_a: assert property (bus_grant_out |-> addr_oe == 24'h0 &&
        !ube_oe && !status_oe && data_cpu_oe == 16'h0)
        else $error("driver active while bus granted");
    grant_rise_a: assert property ($rose(bus_req) |-> ##[1:60] bus_grant_out)
        else $error("grant not given");
    grant_fall_a: assert property ($fell(bus_req) |-> ##[1:20] !bus_grant_out)
        else $error("grant not dropped");
    grant_cause_a: assert property ($rose(bus_grant_out) |->
        bus_req && $past(addr_oe) == 24'h0)
        else $error("grant before float or without request");
    wr_data_a: assert property (|data_cpu_oe |-> last_st_q == lbc_pkg::ST_10)
        else $error("data driven outside write cycle");
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    typedef struct {
        lbc_pkg::lbc_cyc_t cyc;
        logic [23:0]       adr;
        logic [1:0]        ln;
        logic [15:0]       wd;
        logic [15:0]       rd;
    } lbc_row_t;

    logic              core_clk, nrst, req_valid, want_bus, sync_pulse;
    lbc_pkg::lbc_cyc_t req_cyc, cyc_type, s_type;
    logic [23:0]       req_addr, cyc_addr, s_addr;
    logic [1:0]        req_lanes, cyc_lanes, s_lanes;
    logic [15:0]       req_wdata, rd_data, rsp_rdata, wr_data, s_wd, s_rd;
    logic              req_ready, rsp_valid, proc_phase, cyc_valid;
    logic              wr_valid, granted, s_mio, p;
    int                num_errors, checked, n_cyc, n_wr, n_rsp;
    bit                tk;
    lbc_row_t          rows[7];

    lbc_bus_if lbc_bus_if_i ();
    lbc_cpu_end lbc_cpu_end_i (.core_clk(core_clk), .nrst(nrst),
        .bus(lbc_bus_if_i), .req_valid(req_valid), .req_cyc(req_cyc),
        .req_addr(req_addr), .req_lanes(req_lanes), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .proc_phase(proc_phase));
    lbc_ctl_end lbc_ctl_end_i (.core_clk(core_clk), .nrst(nrst),
        .bus(lbc_bus_if_i), .want_bus(want_bus), .sync_pulse(sync_pulse),
        .rd_data(rd_data), .cyc_valid(cyc_valid), .cyc_type(cyc_type),
        .cyc_addr(cyc_addr), .cyc_lanes(cyc_lanes), .wr_valid(wr_valid),
        .wr_data(wr_data), .granted(granted));
    lbc_bus_properties lbc_bus_properties_i (.core_clk(core_clk),
        .nrst(nrst), .addr(lbc_bus_if_i.addr),
        .addr_oe(lbc_bus_if_i.addr_oe),
        .upper_byte_lane_enable_n(lbc_bus_if_i.upper_byte_lane_enable_n),
        .ube_oe(lbc_bus_if_i.ube_oe),
        .cycle_status_hi_n(lbc_bus_if_i.cycle_status_hi_n),
        .cycle_status_lo_n(lbc_bus_if_i.cycle_status_lo_n),
        .status_oe(lbc_bus_if_i.status_oe),
        .mem_io_select(lbc_bus_if_i.mem_io_select),
        .fetch_or_intack_select(lbc_bus_if_i.fetch_or_intack_select),
        .data_cpu_oe(lbc_bus_if_i.data_cpu_oe),
        .bus_req(lbc_bus_if_i.bus_req),
        .bus_grant_out(lbc_bus_if_i.bus_grant_out));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (cyc_valid === 1'b1) begin
            n_cyc++;
            s_type = cyc_type;
            s_addr = cyc_addr;
            s_lanes = cyc_lanes;
        end
        if (wr_valid === 1'b1) begin
            n_wr++;
            s_wd = wr_data;
        end
        if (rsp_valid === 1'b1) begin
            n_rsp++;
            s_rd = rsp_rdata;
        end
        if (lbc_bus_if_i.status_oe === 1'b1 && {lbc_bus_if_i.cycle_status_hi_n,
            lbc_bus_if_i.cycle_status_lo_n} !== lbc_pkg::ST_IDLE) begin
            s_mio = lbc_bus_if_i.mem_io_select;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task conclude;
        $display("Checks: %0d, mismatches: %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Entered at a falling edge; request held until taken or limit runs out
    task issue(input lbc_row_t r, input int limit, output bit taken);
        int n;
        n = 0;
        req_valid = 1'b1;
        req_cyc = r.cyc;
        req_addr = r.adr;
        req_lanes = r.ln;
        req_wdata = r.wd;
        rd_data = r.rd;
        while (req_ready !== 1'b1 && n < limit) begin
            @(negedge core_clk);
            n++;
        end
        taken = (req_ready === 1'b1);
        req_valid = 1'b0;
    endtask

    task run_row(input lbc_row_t r);
        int          c0, w0, r0, n;
        bit          io, wr, rdc, mem;
        logic [15:0] m;
        c0 = n_cyc;
        w0 = n_wr;
        r0 = n_rsp;
        n = 0;
        io = r.cyc inside {lbc_pkg::CYC_IO_RD, lbc_pkg::CYC_IO_WR};
        wr = r.cyc inside {lbc_pkg::CYC_MEM_WR, lbc_pkg::CYC_IO_WR};
        rdc = r.cyc inside {lbc_pkg::CYC_MEM_RD, lbc_pkg::CYC_IO_RD,
                            lbc_pkg::CYC_FETCH, lbc_pkg::CYC_INTACK};
        mem = !io && r.cyc != lbc_pkg::CYC_INTACK;
        m = (r.ln == 2'h0) ? 16'hFFFF : (r.ln == 2'h1) ? 16'hFF00 : 16'h00FF;
        issue(r, 100, tk);
        check(tk, 1);
        while (n_rsp == r0 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        check(n_rsp - r0, 1);
        check(n_cyc - c0, 1);
        check(s_type, r.cyc);
        check(s_addr, io ? {8'h00, r.adr[15:0]} : r.adr);
        check(s_lanes, r.ln);
        check(s_mio, mem);
        check(n_wr - w0, wr);
        if (wr) begin
            check(s_wd & m, r.wd & m);
        end else if (rdc) begin
            check(s_rd & m, r.rd & m);
        end
        @(negedge core_clk);
    endtask

    initial begin
        #(25 * 30000);
        num_errors++;
        conclude();
    end

    initial begin
        rows = '{
            '{lbc_pkg::CYC_MEM_RD, 24'h123456, 2'h0, 16'h0000, 16'hA5C3},
            '{lbc_pkg::CYC_MEM_WR, 24'hABCDE1, 2'h1, 16'h5A77, 16'h0000},
            '{lbc_pkg::CYC_IO_RD,  24'h7F0F10, 2'h2, 16'h0000, 16'h0042},
            '{lbc_pkg::CYC_IO_WR,  24'h0000F2, 2'h0, 16'hBEEF, 16'h0000},
            '{lbc_pkg::CYC_FETCH,  24'hFFFFF0, 2'h0, 16'h0000, 16'h1234},
            '{lbc_pkg::CYC_INTACK, 24'h000000, 2'h0, 16'h0000, 16'h00C8},
            '{lbc_pkg::CYC_HALT,   24'h000002, 2'h0, 16'h0000, 16'h0000}};
        nrst = 1'b0;
        req_valid = 1'b0;
        req_cyc = lbc_pkg::CYC_NONE;
        req_addr = 24'h000000;
        req_lanes = 2'h0;
        req_wdata = 16'h0000;
        rd_data = 16'h0000;
        want_bus = 1'b0;
        sync_pulse = 1'b0;
        repeat (5) @(negedge core_clk);
        check({lbc_bus_if_i.cycle_status_hi_n,
               lbc_bus_if_i.cycle_status_lo_n}, lbc_pkg::ST_IDLE);
        check(lbc_bus_if_i.data_cpu_oe, 16'h0000);
        check(lbc_bus_if_i.bus_grant_out, 1'b0);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        foreach (rows[i]) begin
            run_row(rows[i]);
        end
        // Reserved lane code and empty cycle type must never be taken
        rows[1].ln = 2'h3;
        issue(rows[1], 20, tk);
        check(tk, 0);
        rows[1].ln = 2'h1;
        rows[1].cyc = lbc_pkg::CYC_NONE;
        issue(rows[1], 20, tk);
        check(tk, 0);
        // Odd spacing of the two syncs: an unaligned divider would differ
        sync_pulse = 1'b1;
        repeat (8) @(negedge core_clk);
        p = proc_phase;
        sync_pulse = 1'b0;
        repeat (5) @(negedge core_clk);
        sync_pulse = 1'b1;
        repeat (8) @(negedge core_clk);
        check(proc_phase, p);
        sync_pulse = 1'b0;
        repeat (6) begin
            p = ~proc_phase;
            @(negedge core_clk);
            check(proc_phase, p);
        end
        want_bus = 1'b1;
        repeat (80) begin
            if (granted !== 1'b1) begin
                @(negedge core_clk);
            end
        end
        check(granted, 1'b1);
        check(lbc_bus_if_i.bus_grant_out, 1'b1);
        issue(rows[0], 20, tk);
        check(tk, 0);
        want_bus = 1'b0;
        run_row(rows[3]);
        conclude();
    end
endmodule
`default_nettype wire
